// file: hdl/dstpf_fifo.sv
// dstpf_fifo: flip-flop fifo with registered full flag
`timescale 1ns/100ps
module dstpf_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 8
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // filling and draining sides
  dstpf_strm_if.snk wr,
  dstpf_strm_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);

  logic [W-1:0] mem_q [DEPTH]; // storage
  logic [AW-1:0] wptr_q;       // write index
  logic [AW-1:0] rptr_q;       // read index
  logic [CW-1:0] cnt_q;        // fill level
  logic [CW-1:0] cnt_d;
  logic wr_rdy_q;              // registered not-full
  logic push;
  logic pop;

  // pointer step with wrap, depth need not be a power of two
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + AW'(1));
  endfunction : bump

  assign push = ce && wr.valid && wr_rdy_q;
  assign pop = ce && rd.valid && rd.ready;
  assign wr.ready = wr_rdy_q;
  assign rd.valid = (cnt_q != '0);
  assign rd.data = mem_q[rptr_q];

  // next fill level
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = CW'(cnt_q + CNT_ONE);
    end else if (pop && !push) begin
      cnt_d = CW'(cnt_q - CNT_ONE);
    end
  end

  // pointers, level and ready flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      wr_rdy_q <= 1'b0;
    end else if (ce) begin
      if (push) wptr_q <= bump(wptr_q);
      if (pop) rptr_q <= bump(rptr_q);
      cnt_q <= cnt_d;
      wr_rdy_q <= (cnt_d != CNT_FULL);
    end
  end

  // storage has no reset, the level guards stale words
  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wptr_q] <= wr.data;
    end
  end
endmodule : dstpf_fifo

// file: hdl/dstpf_hdr.sv
// dstpf_hdr: builds one of the four header bytes
`timescale 1ns/100ps
module dstpf_hdr import dstpf_pkg::*; (
  // header byte index and field values
  input wire logic [1:0] idx,
  input wire logic pusi,
  input wire logic [12:0] pid,
  input wire logic [3:0] cc,
  // byte for that index
  output logic [7:0] hdr_byte
);
  // fields in order, most significant bit first
  always_comb begin
    case (idx)
      2'h0: hdr_byte = SYNC_VAL;
      2'h1: hdr_byte = {TEI_CLEAR, pusi, PRIO_CLEAR, pid[12:8]};
      2'h2: hdr_byte = pid[7:0];
      default: hdr_byte = {SCR_CLEAR, AFC_PAYLOAD, cc};
    endcase
  end
endmodule : dstpf_hdr

// file: hdl/dstpf_pkg.sv
// dstpf_pkg: constants and types shared by the transport packet framer
package dstpf_pkg;
  // packet geometry
  localparam logic [7:0] PKT_LEN = 8'hbc;     // 188 bytes per packet
  localparam logic [7:0] POS_LAST = 8'hbb;    // last byte position
  localparam logic [7:0] HDR_LEN = 8'h04;     // header bytes
  localparam logic [7:0] PTR_POS = 8'h04;     // pointer byte position
  localparam logic [7:0] CC_POS = 8'h03;      // header byte holding the cc
  localparam logic [7:0] POS_ZERO = 8'h00;    // first byte position
  // header field values
  localparam logic [7:0] SYNC_VAL = 8'h47;    // packet sync byte
  localparam logic TEI_CLEAR = 1'b0;          // error bit as sent
  localparam logic PRIO_CLEAR = 1'b0;         // reserved priority bit
  localparam logic [1:0] SCR_CLEAR = 2'b00;   // reserved scrambling bits
  localparam logic [1:0] AFC_PAYLOAD = 2'b01; // payload only
  localparam logic [12:0] MAC_PID = 13'h1ffe; // mac stream identifier
  localparam logic [12:0] NULL_PID = 13'h1fff; // null packet identifier
  localparam logic [3:0] CC_NULL = 4'h0;      // cc carried on null packets
  localparam logic [3:0] CC_STEP = 4'h1;      // cc advance per packet
  localparam logic [7:0] STUFF_VAL = 8'hff;   // stuffing byte
  localparam logic [7:0] PTR_ZERO = 8'h00;    // pointer value sent
  // fifo entry layout: {sof, eof, data}
  localparam int FIFO_W = 10;
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int SOF_BIT = 9;
  localparam int EOF_BIT = 8;
  // apb register map
  localparam int APB_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;    // bit0 enable
  localparam logic [7:0] REG_STATUS = 8'h04;  // block state
  localparam logic [7:0] REG_MACCNT = 8'h08;  // mac packets sent
  localparam logic [7:0] REG_NULLCNT = 8'h0c; // null packets sent
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] CNT_STEP = 32'h0000_0001;
  // kind of the packet under way
  typedef enum logic [1:0] {
    K_NULL = 2'b00,   // null packet, all stuffing
    K_CONT = 2'b01,   // mac packet continuing a frame, no pointer
    K_START = 2'b10   // mac packet with pointer byte
  } dstpf_kind_type;
endpackage : dstpf_pkg

// file: hdl/dstpf_strm_if.sv
// dstpf_strm_if: valid/ready word stream between framer parts
`timescale 1ns/100ps
interface dstpf_strm_if #(parameter int W = 10);
  logic [W-1:0] data; // word
  logic valid;        // word offered
  logic ready;        // word taken when valid is also high
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : dstpf_strm_if

// file: hdl/dstpf_top.sv
// dstpf_top: downstream transport packet framer with apb control
// Behaviour
// - continuous back-to-back 188-byte packets, no gaps
// - 4-byte header, then 184 payload bytes
// - header pid marks mac or null packet
// - header, optional pointer, 183 or 184 payload
// - first byte always sync value 0x47
// - transport error bit sent as zero
// - start indicator set exactly when pointer present
// - priority bit always zero on mac packets
// - mac packets carry pid 0x1ffe
// - scrambling bits always 00 on mac
// - adaptation control 01, never adaptation field
// - 4-bit continuity counter kept for mac pid
// - pointer counts bytes to skip before frame
// - unused payload bytes filled with 0xff
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module dstpf_top import dstpf_pkg::*; #(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mac frame bytes in
  input wire logic [7:0] mac_data,
  input wire logic mac_sof,
  input wire logic mac_eof,
  input wire logic mac_valid,
  output logic mac_ready,
  // transport packet bytes out
  output logic [7:0] ts_data,
  output logic ts_sop,
  output logic ts_valid,
  input wire logic ts_ready
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  dstpf_strm_if #(.W(FIFO_W)) wr_if (); // mac side of fifo
  dstpf_strm_if #(.W(FIFO_W)) rd_if (); // framer side of fifo
  logic [7:0] pos_q;           // byte position inside packet
  dstpf_kind_type kind_q;      // kind latched at byte 0
  dstpf_kind_type kind_now;    // kind chosen for a new packet
  dstpf_kind_type kind_cur;    // kind of the byte being built
  logic [3:0] cc_q;            // mac continuity counter
  logic in_frame_q;            // a mac frame is open
  logic en_q;                  // software enable
  logic [7:0] ts_data_q;
  logic ts_sop_q;
  logic ts_valid_q;
  logic [31:0] mac_cnt_q;      // mac packets started
  logic [31:0] null_cnt_q;     // null packets started
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] rd_word;        // read mux
  logic rd_hit;                // address mapped
  logic active;                // packet under way or enabled
  logic adv;                   // one output byte produced
  logic head_sof;
  logic head_eof;
  logic [7:0] head_byte;
  logic pusi;
  logic [12:0] hdr_pid;
  logic [3:0] hdr_cc;
  logic [7:0] hdr_byte;
  logic [7:0] byte_d;
  logic pay_pop;               // payload takes the fifo head
  logic orphan;                // head byte outside any frame
  logic pop;
  logic apb_wr;

  // true for both mac packet kinds
  function automatic logic is_mac(input dstpf_kind_type k);
    is_mac = (k == K_START) || (k == K_CONT);
  endfunction : is_mac

  ////////////////////////////////////////////////////////////////////////////
  // input fifo
  assign wr_if.data = {mac_sof, mac_eof, mac_data};
  assign wr_if.valid = mac_valid;
  assign mac_ready = wr_if.ready; // registered inside the fifo
  assign head_sof = rd_if.data[SOF_BIT];
  assign head_eof = rd_if.data[EOF_BIT];
  assign head_byte = rd_if.data[7:0];
  assign rd_if.ready = pop;

  dstpf_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .wr(wr_if),
    .rd(rd_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // byte scheduling
  // disabling waits for the packet boundary so no partial packet leaves
  assign active = en_q || (pos_q != POS_ZERO);
  assign adv = ce && active && (!ts_valid_q || ts_ready);
  // frame head waiting: pointer packet; open frame: continuation; else null
  assign kind_now = (rd_if.valid && head_sof) ? K_START :
                    in_frame_q ? K_CONT : K_NULL;
  assign kind_cur = (pos_q == POS_ZERO) ? kind_now : kind_q;
  assign pusi = (kind_cur == K_START);
  assign hdr_pid = is_mac(kind_cur) ? MAC_PID : NULL_PID;
  assign hdr_cc = is_mac(kind_cur) ? cc_q : CC_NULL;
  // bytes outside a frame are dropped, they cannot be framed
  assign orphan = ce && rd_if.valid && !in_frame_q && !head_sof;
  assign pop = (adv && pay_pop) || orphan;

  dstpf_hdr u_hdr (
    .idx(pos_q[1:0]),
    .pusi(pusi),
    .pid(hdr_pid),
    .cc(hdr_cc),
    .hdr_byte(hdr_byte)
  );

  // byte selection for the current position
  always_comb begin
    byte_d = STUFF_VAL;
    pay_pop = 1'b0;
    if (pos_q < HDR_LEN) begin
      byte_d = hdr_byte;
    end else if (pos_q == PTR_POS && pusi) begin
      byte_d = PTR_ZERO;
    end else if (is_mac(kind_cur) && rd_if.valid &&
                 (in_frame_q || (head_sof && pusi))) begin
      // new frames only after a pointer, so continuations stay parseable
      byte_d = head_byte;
      pay_pop = 1'b1;
    end else begin
      // an empty fifo inside an open frame also stuffs; the source
      // must keep up once a frame is started
      byte_d = STUFF_VAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // position and kind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q <= POS_ZERO;
      kind_q <= K_NULL;
    end else if (adv) begin
      pos_q <= (pos_q == POS_LAST) ? POS_ZERO : 8'(pos_q + 8'h01);
      if (pos_q == POS_ZERO) kind_q <= kind_now;
    end
  end

  // continuity counter advances after each mac header is sent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_q <= CC_NULL;
    end else if (adv && pos_q == CC_POS && is_mac(kind_q)) begin
      cc_q <= 4'(cc_q + CC_STEP);
    end
  end

  // open-frame tracking from popped flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame_q <= 1'b0;
    end else if (adv && pay_pop) begin
      if (head_eof) in_frame_q <= 1'b0;
      else if (head_sof) in_frame_q <= 1'b1;
    end
  end

  // packet counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_cnt_q <= WORD_ZERO;
      null_cnt_q <= WORD_ZERO;
    end else if (adv && pos_q == POS_ZERO) begin
      if (is_mac(kind_now)) mac_cnt_q <= mac_cnt_q + CNT_STEP;
      else null_cnt_q <= null_cnt_q + CNT_STEP;
    end
  end

  // output byte register, held while the modulator stalls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_data_q <= STUFF_VAL;
      ts_sop_q <= 1'b0;
      ts_valid_q <= 1'b0;
    end else if (adv) begin
      ts_data_q <= byte_d;
      ts_sop_q <= (pos_q == POS_ZERO);
      ts_valid_q <= 1'b1;
    end else if (ce && ts_ready) begin
      ts_valid_q <= 1'b0;
    end
  end

  assign ts_data = ts_data_q;
  assign ts_sop = ts_sop_q;
  assign ts_valid = ts_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait-free access phase
  assign apb_wr = psel && penable && pready_q && pwrite;

  // read mux and decode
  always_comb begin
    rd_word = WORD_ZERO;
    rd_hit = 1'b1;
    if (paddr == REG_CTRL) begin
      rd_word[CTRL_EN_BIT] = en_q;
    end else if (paddr == REG_STATUS) begin
      rd_word = {24'h00_0000, cc_q, 1'b0, rd_if.valid, in_frame_q,
                 active};
    end else if (paddr == REG_MACCNT) begin
      rd_word = mac_cnt_q;
    end else if (paddr == REG_NULLCNT) begin
      rd_word = null_cnt_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // answer is set up in the setup cycle and shown in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= WORD_ZERO;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q <= psel && !penable && !pready_q;
      if (psel && !penable) begin
        prdata_q <= pwrite ? WORD_ZERO : rd_word;
        pslverr_q <= !rd_hit;
      end
    end
  end

  // control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= CTRL_EN_RST;
    end else if (ce && apb_wr && paddr == REG_CTRL) begin
      en_q <= pwdata[CTRL_EN_BIT];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [7:0] acc_cnt_q; // bytes accepted since the last packet start
  logic seen_q;          // a packet start has been accepted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_cnt_q <= POS_ZERO;
      seen_q <= 1'b0;
    end else if (ce && ts_valid_q && ts_ready) begin
      acc_cnt_q <= ts_sop_q ? 8'h01 : 8'(acc_cnt_q + 8'h01);
      if (ts_sop_q) seen_q <= 1'b1;
    end
  end

  property p_pkt_len;
    ce && ts_valid && ts_ready && ts_sop && seen_q |-> acc_cnt_q == PKT_LEN;
  endproperty
  a_pkt_len: assert property (p_pkt_len)
    else $error("packet length is not 188 bytes");

  property p_sync;
    adv && pos_q == POS_ZERO |=> ts_sop && ts_data == SYNC_VAL;
  endproperty
  a_sync: assert property (p_sync)
    else $error("packet does not open with the sync byte");

  property p_tei_prio;
    adv && pos_q == 8'h01 |=> ts_data[7] == TEI_CLEAR &&
      ts_data[5] == PRIO_CLEAR;
  endproperty
  a_tei_prio: assert property (p_tei_prio)
    else $error("error or priority bit not zero");

  property p_pusi;
    adv && pos_q == 8'h01 |=> ts_data[6] == ($past(kind_q) == K_START);
  endproperty
  a_pusi: assert property (p_pusi)
    else $error("start indicator does not match pointer presence");

  property p_pid;
    adv && pos_q == 8'h02 && is_mac(kind_q) |=> ts_data == MAC_PID[7:0];
  endproperty
  a_pid: assert property (p_pid)
    else $error("mac packet pid low byte wrong");

  property p_byte3;
    adv && pos_q == CC_POS && is_mac(kind_q) |=>
      ts_data[7:4] == {SCR_CLEAR, AFC_PAYLOAD} &&
      cc_q == 4'($past(cc_q) + CC_STEP);
  endproperty
  a_byte3: assert property (p_byte3)
    else $error("scrambling, adaptation or counter step wrong");

  property p_pointer;
    adv && pos_q == PTR_POS && kind_q == K_START |->
      head_sof && !pop ##1 ts_data == PTR_ZERO;
  endproperty
  a_pointer: assert property (p_pointer)
    else $error("pointer byte not zero or frame head not next");

  property p_null_stuff;
    adv && pos_q >= HDR_LEN && kind_q == K_NULL |=> ts_data == STUFF_VAL;
  endproperty
  a_null_stuff: assert property (p_null_stuff)
    else $error("null packet payload not stuffing");

  property p_kind;
    adv && pos_q == POS_ZERO && !in_frame_q && !rd_if.valid |=>
      kind_q == K_NULL;
  endproperty
  a_kind: assert property (p_kind)
    else $error("packet without mac data not sent as null");

  c_start: cover property (adv && pos_q == POS_ZERO && kind_now == K_START);
  c_cont: cover property (adv && pos_q == POS_ZERO && kind_now == K_CONT);
  c_null: cover property (adv && pos_q == POS_ZERO && kind_now == K_NULL);
  c_full: cover property (mac_valid && !mac_ready);
endmodule : dstpf_top

// file: verif/downstream_ts_packet_framer_tb.sv
// downstream_ts_packet_framer_tb: apb-driven bench for the packet framer
`timescale 1ns/100ps
module downstream_ts_packet_framer_tb import dstpf_pkg::*; ();
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [7:0] mac_data, ts_data;
  logic mac_sof, mac_eof, mac_valid, mac_ready, ts_sop, ts_valid, busy;
  logic ts_ready = 1'b1;
  logic start = 1'b0;
  logic slow = 1'b0;
  logic [7:0] len = 8'h01;
  logic [7:0] base = 8'h00;
  logic stall = 1'b0;  // throttle the modulator side
  logic en_on = 1'b0;  // stream must run without gaps
  logic pusi, is_mac, hit;
  logic have_cc = 1'b0;
  logic [4:0] pid_hi;
  logic [3:0] cc_last;
  logic [7:0] exp_q[$]; // mac bytes still owed, in order
  logic sof_q[$];       // frame start flag of each owed byte
  int miscompares = 0;
  int comparisons = 0;
  int pos = 0;
  int cyc = 0;
  int n;
  int mac_pkts = 0;
  int null_pkts = 0;
  int wraps = 0;
  int lens[6] = '{30, 183, 184, 1, 200, 12};
  always #5 pclk = ~pclk;
  dstpf_top #(.FIFO_DEPTH(8)) u_dstpf_top (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mac_data(mac_data), .mac_sof(mac_sof),
    .mac_eof(mac_eof), .mac_valid(mac_valid), .mac_ready(mac_ready),
    .ts_data(ts_data), .ts_sop(ts_sop), .ts_valid(ts_valid),
    .ts_ready(ts_ready));
  dstpf_mac_src u_dstpf_mac_src (.pclk(pclk), .presetn(presetn), .ce(ce),
    .start(start), .len(len), .base(base), .slow(slow), .busy(busy),
    .mac_data(mac_data), .mac_sof(mac_sof), .mac_eof(mac_eof),
    .mac_valid(mac_valid), .mac_ready(mac_ready));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  task automatic timeout(input string s);
    miscompares++;
    $display("[FAIL] %s exp done got timeout", s);
    print_verdict();
  endtask : timeout
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 64);
    if (k >= 64) timeout("apb");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic ee);
    apb(1'b0, a, WORD_ZERO);
    chk($sformatf("rdata %h", a), e, rd);
    chk($sformatf("slverr %h", a), ee, err);
  endtask : rdc
  // hand a frame to the source once it is idle; owed bytes queued first
  task automatic send(input int l, input int b, input logic s);
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 8000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 8000) timeout("source idle");
    for (int i = 0; i < l; i++) begin
      exp_q.push_back(8'((b + i) % 254));
      sof_q.push_back(i == 0);
    end
    len <= 8'(l);
    base <= 8'(b);
    slow <= s;
    start <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (busy !== 1'b1 && k < 64);
    if (k >= 64) timeout("source start");
    start <= 1'b0;
  endtask : send
  // payload byte: pointer, stuffing, or the next owed mac byte
  task automatic payload;
    hit = exp_q.size() > 0 && ts_data === exp_q[0];
    if (pos == PTR_POS && pusi) chk("pointer", PTR_ZERO, ts_data);
    else if (!is_mac) chk("null fill", STUFF_VAL, ts_data);
    else if (hit) begin
      if (sof_q[0]) chk("start pusi", 1'b1, pusi);
      if (pusi && pos == PTR_POS + 1) chk("ptr tgt", 1'b1, sof_q[0]);
      void'(exp_q.pop_front());
      void'(sof_q.pop_front());
    end else chk("payload", STUFF_VAL, ts_data);
  endtask : payload
  //////////////////////////////////////////////////////////////////////////
  // modulator side: stall pattern plus packet monitor
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    ts_ready <= stall ? (cyc % 3 != 2) : 1'b1;
    if (presetn && ce && en_on) chk("ts gap", 1'b1, ts_valid);
    if (presetn && ce && ts_valid && ts_ready) begin
      chk("sop", pos == 0, ts_sop);
      case (pos)
        0: chk("sync", SYNC_VAL, ts_data);
        1: begin
          chk("tei", TEI_CLEAR, ts_data[7]);
          chk("prio", PRIO_CLEAR, ts_data[5]);
          pusi = ts_data[6];
          pid_hi = ts_data[4:0];
        end
        2: begin
          is_mac = ({pid_hi, ts_data} == MAC_PID);
          if (!is_mac) chk("pid", NULL_PID, {pid_hi, ts_data});
          if (!is_mac) chk("null pusi", 1'b0, pusi);
        end
        3: begin
          chk("scr afc", {SCR_CLEAR, AFC_PAYLOAD}, ts_data[7:4]);
          if (is_mac) begin
            if (have_cc) chk("cc", 4'(cc_last + CC_STEP), ts_data[3:0]);
            if (have_cc && ts_data[3:0] == 4'h0) wraps++;
            cc_last = ts_data[3:0];
            have_cc = 1'b1;
            mac_pkts++;
          end else begin
            chk("null cc", CC_NULL, ts_data[3:0]);
            null_pkts++;
          end
        end
        default: payload();
      endcase
      pos = (pos == POS_LAST) ? 0 : pos + 1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(REG_CTRL, WORD_ZERO, 1'b0);
    rdc(REG_MACCNT, WORD_ZERO, 1'b0);
    rdc(8'h10, WORD_ZERO, 1'b1);
    apb(1'b1, REG_STATUS, 32'hffff_ffff);
    apb(1'b0, REG_STATUS, WORD_ZERO);
    chk("status active", 1'b0, rd[0]);
    // fill the fifo while the framer is still disabled
    send(30, 0, 1'b0);
    repeat (20) @(posedge pclk);
    chk("mac_ready full", 1'b0, mac_ready);
    apb(1'b0, REG_STATUS, WORD_ZERO);
    chk("status fifo", 1'b1, rd[2]);
    stall <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    @(posedge pclk);
    en_on <= 1'b1;
    rdc(REG_CTRL, 32'h0000_0001, 1'b0);
    // frames of boundary lengths; last ones from a slow source
    for (int i = 0; i < 18; i++) begin
      send(lens[i % 6], i * 7 + 40, i >= 12);
      if (i == 6) begin
        ce <= 1'b0;
        repeat (4) @(posedge pclk);
        ce <= 1'b1;
      end
    end
    n = 0;
    while ((exp_q.size() > 0 || null_pkts == 0) && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20000) timeout("drain");
    // disable mid-packet: the packet must still complete
    apb(1'b1, REG_CTRL, WORD_ZERO);
    en_on <= 1'b0;
    n = 0;
    while (ts_valid !== 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 400) timeout("stop");
    chk("stop pos", 0, pos);
    rdc(REG_MACCNT, mac_pkts, 1'b0);
    rdc(REG_NULLCNT, null_pkts, 1'b0);
    rdc(REG_STATUS, {24'h00_0000, 4'(cc_last + CC_STEP), 4'h0}, 1'b0);
    chk("cc wrap", 1'b1, wraps > 0);
    print_verdict();
  end
endmodule : downstream_ts_packet_framer_tb

// file: verif/dstpf_mac_src.sv
// dstpf_mac_src: behavioural mac sublayer byte source for the framer bench
`timescale 1ns/100ps
module dstpf_mac_src import dstpf_pkg::*; (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // frame command from the bench
  input wire logic start,
  input wire logic [7:0] len,
  input wire logic [7:0] base,
  input wire logic slow,
  output logic busy,
  // mac byte stream toward the framer
  output logic [7:0] mac_data,
  output logic mac_sof,
  output logic mac_eof,
  output logic mac_valid,
  input wire logic mac_ready
);
  logic [7:0] cnt_q;  // index of the byte on offer
  logic [7:0] len_q;  // frame length in bytes
  logic [7:0] base_q; // value of the first byte
  logic slow_q;       // idle cycle after every byte taken
  // byte i of a frame; 0xff is skipped so stuffing never looks like data
  function automatic logic [7:0] byte_at(input logic [7:0] b,
                                         input logic [7:0] i);
    return 8'(({1'b0, b} + {1'b0, i}) % 9'h0fe);
  endfunction : byte_at
  //////////////////////////////////////////////////////////////////////////
  // offer bytes; everything holds while the framer pushes back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      mac_valid <= 1'b0;
      mac_sof <= 1'b0;
      mac_eof <= 1'b0;
      mac_data <= 8'h00;
      cnt_q <= 8'h00;
      len_q <= 8'h01;
      base_q <= 8'h00;
      slow_q <= 1'b0;
    end else if (ce) begin
      if (start && !busy) begin
        // new frame: first byte carries the start flag
        busy <= 1'b1;
        cnt_q <= 8'h00;
        len_q <= len;
        base_q <= base;
        slow_q <= slow;
        mac_valid <= 1'b1;
        mac_sof <= 1'b1;
        mac_eof <= (len == 8'h01);
        mac_data <= byte_at(base, 8'h00);
      end else if (mac_valid && mac_ready) begin
        cnt_q <= cnt_q + 8'h01;
        mac_sof <= 1'b0;
        if (mac_eof || slow_q) begin
          // released line shows the inverse in the first idle cycle, not the stale byte
          mac_valid <= 1'b0;
          mac_eof <= 1'b0;
          mac_data <= ~mac_data;
          busy <= !mac_eof;
        end else begin
          mac_data <= byte_at(base_q, cnt_q + 8'h01);
          mac_eof <= (cnt_q + 8'h01 == len_q - 8'h01);
        end
      end else if (busy && !mac_valid) begin
        // slow mode: offer the next byte after the idle cycle
        mac_valid <= 1'b1;
        mac_data <= byte_at(base_q, cnt_q);
        mac_eof <= (cnt_q == len_q - 8'h01);
      end else if (!mac_valid) begin
        mac_data <= ~mac_data;
      end
    end
  end
endmodule : dstpf_mac_src
